// >>> core/hpd_pkg.sv
// Register map, field layout, timing constants and shared types.
package hpd_pkg;

   // Register offsets on the serial control port.
   localparam logic [7:0] ADR_MOD_CFG = 8'h4d;
   localparam logic [7:0] ADR_PROT_CFG = 8'h4e;
   localparam logic [7:0] ADR_PROT_TIME = 8'h4f;
   localparam logic [7:0] ADR_DET_CFG = 8'h51;
   localparam logic [7:0] ADR_DET_START = 8'h52;
   localparam logic [7:0] ADR_RES_HI = 8'h53;
   localparam logic [7:0] ADR_SUP_HI = 8'h55;
   localparam logic [7:0] ADR_MEAS_LO = 8'h57;
   localparam logic [7:0] ADR_OSC_TRIM = 8'h5a;
   localparam logic [7:0] ADR_IDENT = 8'h64;
   localparam logic [7:0] ADR_EDGE = 8'h77;

   // Reset values.
   localparam logic [7:0] RST_MOD_CFG = 8'h28;
   localparam logic RST_PROT_EN = 1'h1;
   localparam logic [6:0] RST_PROT_LEVEL = 7'h3f;
   localparam logic [7:0] RST_PROT_TIME = 8'h32;
   localparam logic [2:0] RST_ADC_SEL = 3'h2;
   localparam logic IDENT_TOP_VALUE = 1'h1;

   // Field positions.
   localparam int BIT_PROT_EN = 7;
   localparam int BIT_WAVE_STYLE = 4;
   localparam int BIT_DIAG_MODE = 4;
   localparam int BIT_SUP_GO = 1;
   localparam int BIT_RES_GO = 0;
   localparam int BIT_IDENT_TOP = 7;
   localparam int BIT_ADDR_PIN = 6;
   localparam int BIT_PIN_CNT = 0;
   localparam int LSB_TRIM_DATA = 1;
   localparam int LSB_EDGE = 6;
   localparam int LSB_RES_LO = 0;
   localparam int LSB_SUP_LO = 4;

   // Protection time base: one unit is a three-thousandth of a second.
   localparam int CLK_HZ = 250_000_000;
   localparam int PROT_UNIT_HZ = 3000;
   localparam int PROT_UNIT_CYC = (CLK_HZ + PROT_UNIT_HZ - 1) / PROT_UNIT_HZ;

   // Measurement sequencer states.
   typedef enum {MS_IDLE, MS_RES, MS_SUP} hpd_meas_state_type;

   // Request to the analog measurement path.
   typedef struct packed {
      logic start;
      logic supply;
   } hpd_meas_req_type;

   // Ten-bit results of both measurements.
   typedef struct packed {
      logic [9:0] res;
      logic [9:0] sup;
   } hpd_result_type;

   // Sense gain for a three-bit gain code.
   function automatic logic [5:0] hpd_gain_of(input logic [2:0] code);
      case (code)
         3'h0: hpd_gain_of = 6'h01;
         3'h1: hpd_gain_of = 6'h02;
         3'h2: hpd_gain_of = 6'h04;
         3'h3: hpd_gain_of = 6'h05;
         3'h4: hpd_gain_of = 6'h08;
         3'h5: hpd_gain_of = 6'h0a;
         3'h6: hpd_gain_of = 6'h14;
         default: hpd_gain_of = 6'h28;
      endcase
   endfunction : hpd_gain_of

endpackage : hpd_pkg

// >>> core/hpd_prot_timer.sv
// Drive output over-level timer that pulls both outputs down.
`timescale 1ns/1ns
`default_nettype none
module hpd_prot_timer #(
   parameter int UNIT_CYC = hpd_pkg::PROT_UNIT_CYC
) (
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   input wire logic enable_i,
   input wire logic [6:0] level_i,
   input wire logic [7:0] duration_i,
   input wire logic [7:0] pos_frac_i,
   input wire logic [7:0] neg_frac_i,
   output logic pulldown_o
);
   localparam int PW = $clog2(UNIT_CYC + 1);

   logic [PW-1:0] pre_r;
   logic [8:0] units_r;
   logic pulldown_r;
   wire over;
   wire tick;
   wire trip;

   // Either output at or above level/128 of supply while enabled.
   assign over = enable_i && ((pos_frac_i >= {1'b0, level_i}) ||
                              (neg_frac_i >= {1'b0, level_i})); // [RQ1]
   assign tick = (pre_r == PW'(UNIT_CYC - 1));
   assign trip = over && (units_r >= {1'b0, duration_i}); // [RQ1]
   assign pulldown_o = pulldown_r;

   // Time units accumulate only while the level is held.
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pre_r <= '0;
         units_r <= '0;
      end else if (!over) begin
         pre_r <= '0;
         units_r <= '0;
      end else begin
         pre_r <= tick ? '0 : pre_r + 1'b1;
         units_r <= (tick && !units_r[8]) ? units_r + 1'b1 : units_r;
      end
   end

   // The pull-down stays latched until the enable is cleared.
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pulldown_r <= 1'b0;
      end else begin
         pulldown_r <= enable_i && (pulldown_r || trip); // [RQ1]
      end
   end

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_b_i);

   pulldown_cause_a: assert property ( // [RQ1]
      $rose(pulldown_o) |-> $past(over) && $past(units_r) >= $past(duration_i))
      else $error("Pull-down rose without a held over-level.");
   pulldown_release_a: assert property ( // [RQ1]
      !enable_i |=> !pulldown_o)
      else $error("Pull-down did not release after disable.");
   pulldown_cov_c: cover property ($rose(pulldown_o));

endmodule : hpd_prot_timer
`default_nettype wire

// >>> core/hpd_measure.sv
// Sequencer for resistance and supply measurements and their results.
`timescale 1ns/1ns
`default_nettype none
module hpd_measure (
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   input wire logic res_go_i,
   input wire logic sup_go_i,
   input wire logic diag_mode_i,
   input wire logic adc_done_i,
   input wire logic [9:0] adc_code_i,
   output hpd_pkg::hpd_meas_req_type req_o,
   output logic res_done_o,
   output logic sup_done_o,
   output hpd_pkg::hpd_result_type result_o
);
   hpd_pkg::hpd_meas_state_type state_r;
   hpd_pkg::hpd_meas_req_type req_r;
   hpd_pkg::hpd_result_type result_r;
   logic res_done_r;
   logic sup_done_r;
   wire res_fin;
   wire sup_fin;

   assign res_fin = (state_r == hpd_pkg::MS_RES) && adc_done_i;
   assign sup_fin = (state_r == hpd_pkg::MS_SUP) && adc_done_i;
   assign req_o = req_r;
   // Completion is shown in the finishing cycle itself, so the go bit clears
   // on the same edge the sequencer goes idle and cannot start a second run.
   assign res_done_o = res_fin;
   assign sup_done_o = sup_fin;
   assign result_o = result_r;

   // Resistance goes first when both are pending and the mode select is set.
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_r <= hpd_pkg::MS_IDLE;
         req_r <= '0;
      end else begin
         req_r.start <= 1'b0;
         case (state_r)
            hpd_pkg::MS_IDLE: begin
               if (res_go_i && diag_mode_i) begin
                  state_r <= hpd_pkg::MS_RES; // [RQ8] [RQ5]
                  req_r <= '{start: 1'b1, supply: 1'b0};
               end else if (sup_go_i) begin
                  state_r <= hpd_pkg::MS_SUP; // [RQ7]
                  req_r <= '{start: 1'b1, supply: 1'b1};
               end
            end
            hpd_pkg::MS_RES: if (adc_done_i) state_r <= hpd_pkg::MS_IDLE;
            hpd_pkg::MS_SUP: if (adc_done_i) state_r <= hpd_pkg::MS_IDLE;
            default: state_r <= hpd_pkg::MS_IDLE;
         endcase
      end
   end

   // Results change only when a measurement of that kind completes.
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         result_r <= '0; // [RQ11]
         res_done_r <= 1'b0;
         sup_done_r <= 1'b0;
      end else begin
         if (res_fin) result_r.res <= adc_code_i; // [RQ17] [RQ9]
         if (sup_fin) result_r.sup <= adc_code_i; // [RQ17] [RQ10]
         res_done_r <= res_fin;
         sup_done_r <= sup_fin;
      end
   end

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_b_i);

   result_hold_a: assert property ( // [RQ17]
      $changed(result_r) |-> res_done_r || sup_done_r)
      else $error("Result changed without a completed measurement.");
   res_capture_a: assert property ( // [RQ9]
      res_fin |=> result_r.res == $past(adc_code_i) && res_done_r)
      else $error("Resistance code not captured on completion.");
   res_start_a: assert property ( // [RQ8]
      req_r.start && !req_r.supply |-> $past(res_go_i && diag_mode_i))
      else $error("Resistance start without go and mode select.");
   sup_start_a: assert property ( // [RQ7]
      req_r.start && req_r.supply |-> $past(sup_go_i))
      else $error("Supply start without its go bit.");
   res_meas_c: cover property (req_r.start && !req_r.supply ##[1:50] res_fin);
   sup_meas_c: cover property (req_r.start && req_r.supply ##[1:50] sup_fin);

endmodule : hpd_measure
`default_nettype wire

// >>> core/hpd_diag_protect_regs.sv
// Register bank for output protection, diagnostics, trim and edge rate.
//
// Summary of operation
// RQ1: Held over-level output beyond duration pulls outputs down.
// RQ2: Level in bits 6:0, enable bit 7.
// RQ3: Eight-bit duration in thirds of milliseconds.
// RQ4: Modulation bit 4 picks half or full wave.
// RQ5: Mode select bit 4 enables resistance diagnosis.
// RQ6: ADC clock is 12MHz over two-to-code.
// RQ7: Supply go bit starts a supply measurement.
// RQ8: Resistance go bit starts a load measurement.
// RQ9: Resistance code is ten bits, split high/low.
// RQ10: Supply code is ten bits, split high/low.
// RQ11: Results read-only, reset zero, spare bits zero.
// RQ12: Six-bit signed oscillator trim, zero nominal.
// RQ13: Identity bit 6 flags address pin variant.
// RQ14: Identity bit 0 flags pin-count variant.
// RQ15: Two-bit output edge rate, slowest at zero.
// RQ16: Sense gain code maps to eight gains.
// RQ17: Results update only on measurement completion.
`timescale 1ns/1ns
`default_nettype none
module hpd_diag_protect_regs #(
   parameter int PROT_UNIT_CYC = hpd_pkg::PROT_UNIT_CYC,
   parameter logic ADDR_PIN_VARIANT = 1'h0,
   parameter logic PIN_COUNT_VARIANT = 1'h0
) (
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   input wire logic [4:0] trim_data_i,
   input wire logic [2:0] sense_gain_select_i,
   input wire logic [7:0] drive_out_pos_frac_i,
   input wire logic [7:0] drive_out_neg_frac_i,
   input wire logic adc_done_i,
   input wire logic [9:0] adc_code_i,
   output logic drive_pulldown_o,
   output logic shutdown_wave_style_o,
   output logic diag_mode_select_o,
   output logic [2:0] adc_clk_sel_o,
   output logic [7:0] adc_div_ratio_o,
   output logic meas_start_o,
   output logic meas_supply_o,
   output logic [5:0] sense_gain_o,
   output logic [5:0] osc_trim_o,
   output logic osc_trim_up_o,
   output logic [5:0] osc_trim_steps_o,
   output logic [1:0] output_edge_rate_o
);
   // Software visible state.
   logic [7:0] mod_cfg_r;
   logic prot_en_r;
   logic [6:0] prot_level_r;
   logic [7:0] prot_time_r;
   logic diag_mode_r;
   logic [2:0] adc_sel_r;
   logic res_go_r;
   logic res_go_nxt;
   logic sup_go_r;
   logic sup_go_nxt;
   logic [5:0] osc_trim_r;
   logic [1:0] edge_r;
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;

   // Measurement side.
   hpd_pkg::hpd_meas_req_type meas_req;
   hpd_pkg::hpd_result_type result;
   logic res_done;
   logic sup_done;

   // Address hits.
   wire hit_mod;
   wire hit_pcfg;
   wire hit_ptime;
   wire hit_dcfg;
   wire hit_dstart;
   wire hit_res;
   wire hit_sup;
   wire hit_lo;
   wire hit_trim;
   wire hit_id;
   wire hit_edge;
   wire [7:0] val_pcfg;
   wire [7:0] val_dcfg;
   wire [7:0] val_dstart;
   wire [7:0] val_lo;
   wire [7:0] val_id;
   wire [7:0] val_trim;
   wire [7:0] val_edge;

   // Decode of the register address.
   assign hit_mod = (reg_addr_i == hpd_pkg::ADR_MOD_CFG);
   assign hit_pcfg = (reg_addr_i == hpd_pkg::ADR_PROT_CFG);
   assign hit_ptime = (reg_addr_i == hpd_pkg::ADR_PROT_TIME);
   assign hit_dcfg = (reg_addr_i == hpd_pkg::ADR_DET_CFG);
   assign hit_dstart = (reg_addr_i == hpd_pkg::ADR_DET_START);
   assign hit_res = (reg_addr_i == hpd_pkg::ADR_RES_HI);
   assign hit_sup = (reg_addr_i == hpd_pkg::ADR_SUP_HI);
   assign hit_lo = (reg_addr_i == hpd_pkg::ADR_MEAS_LO);
   assign hit_trim = (reg_addr_i == hpd_pkg::ADR_OSC_TRIM);
   assign hit_id = (reg_addr_i == hpd_pkg::ADR_IDENT);
   assign hit_edge = (reg_addr_i == hpd_pkg::ADR_EDGE);

   // Read values assembled from fields; spare bits read as zero.
   assign val_pcfg = {prot_en_r, prot_level_r}; // [RQ2]
   assign val_dcfg = {3'h0, diag_mode_r, 1'h0, adc_sel_r}; // [RQ5] [RQ6]
   assign val_dstart = {6'h00, sup_go_r, res_go_r};
   assign val_lo = {2'h0, result.sup[1:0], 2'h0, result.res[1:0]}; // [RQ11]
   assign val_id = {hpd_pkg::IDENT_TOP_VALUE, ADDR_PIN_VARIANT,
                    trim_data_i, PIN_COUNT_VARIANT}; // [RQ13] [RQ14]
   assign val_trim = {2'h0, osc_trim_r};
   assign val_edge = {edge_r, 6'h00}; // [RQ15]

   // Read multiplexer; an unmapped address reads as zero.
   assign rdata_nxt = ({8{hit_mod}} & mod_cfg_r) |
                      ({8{hit_pcfg}} & val_pcfg) |
                      ({8{hit_ptime}} & prot_time_r) |
                      ({8{hit_dcfg}} & val_dcfg) |
                      ({8{hit_dstart}} & val_dstart) |
                      ({8{hit_res}} & result.res[9:2]) | // [RQ9]
                      ({8{hit_sup}} & result.sup[9:2]) | // [RQ10]
                      ({8{hit_lo}} & val_lo) |
                      ({8{hit_trim}} & val_trim) |
                      ({8{hit_id}} & val_id) |
                      ({8{hit_edge}} & val_edge);

   // Go bits: a write sets or clears, completion clears; a write wins.
   assign res_go_nxt = (reg_wr_i && hit_dstart) ?
                       reg_wdata_i[hpd_pkg::BIT_RES_GO] :
                       (res_go_r && !res_done); // [RQ8]
   assign sup_go_nxt = (reg_wr_i && hit_dstart) ?
                       reg_wdata_i[hpd_pkg::BIT_SUP_GO] :
                       (sup_go_r && !sup_done); // [RQ7]

   // Read data is registered on each read strobe and held otherwise.
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rdata_r <= 8'h00;
      end else if (reg_rd_i) begin
         rdata_r <= rdata_nxt;
      end
   end

   // Protection and modulation registers.
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         mod_cfg_r <= hpd_pkg::RST_MOD_CFG; // [RQ4]
         prot_en_r <= hpd_pkg::RST_PROT_EN; // [RQ2]
         prot_level_r <= hpd_pkg::RST_PROT_LEVEL; // [RQ2]
         prot_time_r <= hpd_pkg::RST_PROT_TIME; // [RQ3]
      end else begin
         if (reg_wr_i && hit_mod) mod_cfg_r <= reg_wdata_i;
         if (reg_wr_i && hit_pcfg) begin
            prot_en_r <= reg_wdata_i[hpd_pkg::BIT_PROT_EN];
            prot_level_r <= reg_wdata_i[6:0];
         end
         if (reg_wr_i && hit_ptime) prot_time_r <= reg_wdata_i;
      end
   end

   // Diagnostic control registers.
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         diag_mode_r <= 1'b0; // [RQ5]
         adc_sel_r <= hpd_pkg::RST_ADC_SEL; // [RQ6]
         res_go_r <= 1'b0;
         sup_go_r <= 1'b0;
      end else begin
         if (reg_wr_i && hit_dcfg) begin
            diag_mode_r <= reg_wdata_i[hpd_pkg::BIT_DIAG_MODE];
            adc_sel_r <= reg_wdata_i[2:0];
         end
         res_go_r <= res_go_nxt;
         sup_go_r <= sup_go_nxt;
      end
   end

   // Trim and edge-rate registers.
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         osc_trim_r <= 6'h00;
         edge_r <= 2'h0; // [RQ15]
      end else begin
         if (reg_wr_i && hit_trim) osc_trim_r <= reg_wdata_i[5:0];
         if (reg_wr_i && hit_edge) begin
            edge_r <= reg_wdata_i[hpd_pkg::LSB_EDGE+:2];
         end
      end
   end

   // Over-level protection timer on both drive outputs.
   hpd_prot_timer #(
      .UNIT_CYC(PROT_UNIT_CYC)
   ) u_prot (
      .sys_clk_i(sys_clk_i),
      .rst_b_i(rst_b_i),
      .enable_i(prot_en_r), // [RQ1]
      .level_i(prot_level_r),
      .duration_i(prot_time_r), // [RQ3]
      .pos_frac_i(drive_out_pos_frac_i),
      .neg_frac_i(drive_out_neg_frac_i),
      .pulldown_o(drive_pulldown_o)
   );

   // Measurement sequencer and result capture.
   hpd_measure u_meas (
      .sys_clk_i(sys_clk_i),
      .rst_b_i(rst_b_i),
      .res_go_i(res_go_r),
      .sup_go_i(sup_go_r),
      .diag_mode_i(diag_mode_r),
      .adc_done_i(adc_done_i),
      .adc_code_i(adc_code_i),
      .req_o(meas_req),
      .res_done_o(res_done),
      .sup_done_o(sup_done),
      .result_o(result)
   );

   // Trim is two's complement: positive raises, negative lowers.
   assign osc_trim_up_o = !osc_trim_r[5] && (osc_trim_r != 6'h00); // [RQ12]
   assign osc_trim_steps_o = osc_trim_r[5] ? 6'((~osc_trim_r) + 6'h01) :
                             osc_trim_r; // [RQ12]

   // Configuration outputs toward the analog side.
   assign reg_rdata_o = rdata_r;
   assign shutdown_wave_style_o = mod_cfg_r[hpd_pkg::BIT_WAVE_STYLE]; // [RQ4]
   assign diag_mode_select_o = diag_mode_r;
   assign adc_clk_sel_o = adc_sel_r;
   assign adc_div_ratio_o = 8'(8'h01 << adc_sel_r); // [RQ6]
   assign meas_start_o = meas_req.start;
   assign meas_supply_o = meas_req.supply;
   assign sense_gain_o = hpd_pkg::hpd_gain_of(sense_gain_select_i); // [RQ16]
   assign osc_trim_o = osc_trim_r;
   assign output_edge_rate_o = edge_r;

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_b_i);

   prot_cfg_read_a: assert property ( // [RQ2]
      reg_rd_i && hit_pcfg |=> reg_rdata_o == {$past(prot_en_r),
                                               $past(prot_level_r)})
      else $error("Protection config read mismatch.");
   prot_time_rw_a: assert property ( // [RQ3]
      reg_wr_i && hit_ptime ##1 reg_rd_i && hit_ptime && !reg_wr_i
      |=> reg_rdata_o == $past(reg_wdata_i, 2))
      else $error("Protection duration did not read back.");
   wave_style_a: assert property ( // [RQ4]
      reg_wr_i && hit_mod |=> shutdown_wave_style_o ==
                             $past(reg_wdata_i[hpd_pkg::BIT_WAVE_STYLE]))
      else $error("Wave style did not follow the write.");
   adc_sel_a: assert property ( // [RQ6]
      reg_wr_i && hit_dcfg |=> adc_clk_sel_o == $past(reg_wdata_i[2:0])
                               && adc_div_ratio_o[adc_clk_sel_o])
      else $error("ADC clock select did not follow the write.");
   low_spare_a: assert property ( // [RQ11]
      reg_rd_i && hit_lo |=> reg_rdata_o[7:6] == 2'h0 &&
                             reg_rdata_o[3:2] == 2'h0)
      else $error("Spare bits of the low result register not zero.");
   res_low_a: assert property ( // [RQ9]
      reg_rd_i && hit_lo |=> reg_rdata_o[1:0] == $past(result.res[1:0]))
      else $error("Resistance low bits misplaced.");
   sup_high_a: assert property ( // [RQ10]
      reg_rd_i && hit_sup |=> reg_rdata_o == $past(result.sup[9:2]))
      else $error("Supply high bits misplaced.");
   ident_a: assert property ( // [RQ13] [RQ14]
      reg_rd_i && hit_id |=> reg_rdata_o[6] == ADDR_PIN_VARIANT &&
                             reg_rdata_o[0] == PIN_COUNT_VARIANT)
      else $error("Identity variant bits wrong.");
   sup_go_clear_a: assert property ( // [RQ7]
      sup_done && !(reg_wr_i && hit_dstart) |=> !sup_go_r)
      else $error("Supply go bit not cleared on completion.");
   trim_dir_a: assert property ( // [RQ12]
      osc_trim_o[5] |-> !osc_trim_up_o && osc_trim_steps_o != 6'h00)
      else $error("Negative trim reported as raising.");
   edge_rate_a: assert property ( // [RQ15]
      reg_wr_i && hit_edge |=> output_edge_rate_o ==
                               $past(reg_wdata_i[7:6]))
      else $error("Edge rate did not follow the write.");
   gain_top_a: assert property ( // [RQ16]
      sense_gain_select_i == 3'h7 |-> sense_gain_o == 6'h28)
      else $error("Top gain code not forty.");

   both_go_c: cover property (res_go_r && sup_go_r && diag_mode_r);
   pulldown_c: cover property ($rose(drive_pulldown_o));
   go_race_c: cover property (res_done && reg_wr_i && hit_dstart);

endmodule : hpd_diag_protect_regs
`default_nettype wire

// >>> test/hpd_adc_model.sv
// Behavioural analog measurement path answering measurement starts.
`timescale 1ns/1ns
`default_nettype none
module hpd_adc_model #(
   parameter int DELAY = 5,
   parameter logic [9:0] RES_CODE = 10'h2a5,
   parameter logic [9:0] SUP_CODE = 10'h1c6
) (
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   input wire logic start_i,
   input wire logic supply_i,
   output logic done_o,
   output logic [9:0] code_o
);
   int cnt_r;
   logic kind_r;
   // Answers a start after DELAY cycles; the code is scrambled once stale.
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cnt_r <= 0;
         kind_r <= 1'b0;
         done_o <= 1'b0;
         code_o <= 10'h000;
      end else begin
         done_o <= 1'b0;
         if (done_o) code_o <= ~code_o;
         if (start_i) begin
            cnt_r <= DELAY;
            kind_r <= supply_i;
         end else if (cnt_r != 0) begin
            cnt_r <= cnt_r - 1;
            if (cnt_r == 1) begin
               done_o <= 1'b1;
               code_o <= kind_r ? SUP_CODE : RES_CODE;
            end
         end
      end
   end
endmodule : hpd_adc_model
`default_nettype wire

// >>> test/hpd_diag_protect_regs_bench.sv
// Self-checking bench for the protection and diagnostic register bank.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin \
n_errors++; $display("CHECK FAILED %s expected %h seen %h", nm, e, g); \
end end
module hpd_diag_protect_regs_bench;
   logic sys_clk_i = 1'b0, rst_b_i = 1'b0, wr = 1'b0, rd = 1'b0;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, pos = 8'h00, neg = 8'h00;
   logic [2:0] gsel = 3'h0, asel;
   logic [5:0] gain, trim, steps;
   logic [7:0] ratio;
   logic [1:0] edge_r;
   logic pd, wave, dmode, mst, msup, adone, up;
   logic [9:0] acode;
   logic [7:0] v;
   int n_errors = 0, check_count = 0;
   logic [7:0] ra [12] = '{8'h4d, 8'h4e, 8'h4f, 8'h51, 8'h52, 8'h53, 8'h55,
      8'h57, 8'h5a, 8'h64, 8'h77, 8'h50};
   logic [7:0] rv [12] = '{8'h28, 8'hbf, 8'h32, 8'h02, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'haa, 8'h00, 8'h00};
   logic [5:0] gt [8] = '{6'h01, 6'h02, 6'h04, 6'h05, 6'h08, 6'h0a, 6'h14,
      6'h28};
   hpd_diag_protect_regs #(.PROT_UNIT_CYC(4)) uut (.sys_clk_i(sys_clk_i),
      .rst_b_i(rst_b_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
      .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
      .trim_data_i(5'h15), .sense_gain_select_i(gsel),
      .drive_out_pos_frac_i(pos), .drive_out_neg_frac_i(neg),
      .adc_done_i(adone), .adc_code_i(acode), .drive_pulldown_o(pd),
      .shutdown_wave_style_o(wave), .diag_mode_select_o(dmode),
      .adc_clk_sel_o(asel), .adc_div_ratio_o(ratio), .meas_start_o(mst),
      .meas_supply_o(msup), .sense_gain_o(gain), .osc_trim_o(trim),
      .osc_trim_up_o(up), .osc_trim_steps_o(steps),
      .output_edge_rate_o(edge_r));
   hpd_adc_model adc (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
      .start_i(mst), .supply_i(msup), .done_o(adone), .code_o(acode));
   // Clock at 250 MHz.
   initial begin
      forever #2 sys_clk_i = ~sys_clk_i;
   end
   // One register write, strobe held for a single edge.
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk_i);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge sys_clk_i);
      wr <= 1'b0;
   endtask : wr_reg
   // One register read; data lands on the edge that takes the strobe.
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge sys_clk_i);
      addr <= a;
      rd <= 1'b1;
      @(posedge sys_clk_i);
      rd <= 1'b0;
      #1 d = rdata;
   endtask : rd_reg
   // Prints counts and the verdict, then ends the run.
   task automatic test_done();
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : test_done
   // Cuts a hang short.
   initial begin
      repeat (20000) @(posedge sys_clk_i);
      n_errors++;
      test_done();
   end
   // Main test sequence.
   initial begin
      repeat (8) @(posedge sys_clk_i);
      rst_b_i <= 1'b1;
      foreach (ra[i]) begin
         rd_reg(ra[i], v);
         `CHK("reset value", rv[i], v)
      end
      `CHK("adc ratio", 8'h04, ratio)
      $display("test reset done");
      wr_reg(8'h4e, 8'hc0);
      wr_reg(8'h4f, 8'h03);
      @(posedge sys_clk_i);
      pos <= 8'h3f;
      repeat (20) @(posedge sys_clk_i);
      #1 `CHK("below level", 1'b0, pd)
      @(posedge sys_clk_i);
      pos <= 8'h40;
      repeat (12) @(posedge sys_clk_i);
      #1 `CHK("early trip", 1'b0, pd)
      @(posedge sys_clk_i);
      #1 `CHK("trip", 1'b1, pd)
      @(posedge sys_clk_i);
      pos <= 8'h00;
      neg <= 8'h40;
      wr_reg(8'h4e, 8'h40);
      rd_reg(8'h4e, v);
      `CHK("release", 1'b0, pd)
      wr_reg(8'h4e, 8'hc0);
      repeat (16) @(posedge sys_clk_i);
      #1 `CHK("neg trip", 1'b1, pd)
      wr_reg(8'h4e, 8'h40);
      $display("test protect done");
      wr_reg(8'h4d, 8'h10);
      wr_reg(8'h4f, 8'hff);
      wr_reg(8'h51, 8'hff);
      wr_reg(8'h5a, 8'hff);
      wr_reg(8'h77, 8'hff);
      wr_reg(8'h53, 8'hff);
      rd_reg(8'h51, v);
      `CHK("detect cfg", 8'h17, v)
      `CHK("wave style", 1'b1, wave)
      `CHK("adc ratio", 8'h80, ratio)
      `CHK("trim down", {1'b0, 6'h01}, {up, steps})
      `CHK("edge rate", 2'h3, edge_r)
      `CHK("diag mode", 1'b1, dmode)
      `CHK("adc sel", 3'h7, asel)
      `CHK("trim raw", 6'h3f, trim)
      rd_reg(8'h4f, v);
      `CHK("time rw", 8'hff, v)
      rd_reg(8'h5a, v);
      `CHK("trim rw", 8'h3f, v)
      rd_reg(8'h53, v);
      `CHK("read only", 8'h00, v)
      wr_reg(8'h5a, 8'h1f);
      @(posedge sys_clk_i);
      #1 `CHK("trim up", {1'b1, 6'h1f}, {up, steps})
      wr_reg(8'h5a, 8'h20);
      @(posedge sys_clk_i);
      #1 `CHK("trim min", {1'b0, 6'h20}, {up, steps})
      foreach (gt[i]) begin
         @(posedge sys_clk_i);
         gsel <= 3'(i);
         #1 `CHK("gain", gt[i], gain)
      end
      $display("test fields done");
      wr_reg(8'h51, 8'h02);
      wr_reg(8'h52, 8'h01);
      repeat (20) @(posedge sys_clk_i);
      rd_reg(8'h52, v);
      `CHK("pending", 8'h01, v)
      rd_reg(8'h53, v);
      `CHK("no result", 8'h00, v)
      wr_reg(8'h52, 8'h03);
      wr_reg(8'h51, 8'h12);
      v = 8'hff;
      for (int k = 0; k < 50 && v != 8'h00; k++) rd_reg(8'h52, v);
      `CHK("go clear", 8'h00, v)
      rd_reg(8'h53, v);
      `CHK("res high", 8'ha9, v)
      rd_reg(8'h55, v);
      `CHK("sup high", 8'h71, v)
      rd_reg(8'h57, v);
      `CHK("low bits", 8'h21, v)
      repeat (10) @(posedge sys_clk_i);
      rd_reg(8'h53, v);
      `CHK("res held", 8'ha9, v)
      `CHK("last kind", 1'b0, msup)
      $display("test measure done");
      test_done();
   end
endmodule : hpd_diag_protect_regs_bench
`default_nettype wire
